// File: logic/asp_serial_port.sv
// Serial control and readout port of the sampling converter
`timescale 1ns/10ps
module asp_serial_port
   import asp_pkg::*;
#(
   parameter bit VARIANT_DUAL = 1'b1
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // Serial pins from the host
   input  wire logic        chip_select_shutdown_n,
   input  wire logic        shift_clock,
   input  wire logic        serial_in,
   // Serial output pin, two signals
   output logic             serial_out,
   output logic             serial_out_oe,
   // Analog core control
   input  wire logic        comparator_above,
   output logic [11:0]      dac_code,
   output logic [1:0]       mux_plus,
   output logic [1:0]       mux_minus,
   output logic             sample_enable,
   output logic             bias_on,
   output logic             powered,
   // Result
   output logic [11:0]      result,
   output logic             result_valid
);

   // ==========================================================
   // Pin synchronisers
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] sync1;
   logic [PIN_COUNT-1:0] sync2;
   logic [PIN_COUNT-1:0] sync3;
   logic [PIN_COUNT-1:0] pin_q;
   logic [PIN_COUNT-1:0] pin_d;

   assign pin_raw = {serial_in, shift_clock, chip_select_shutdown_n};

   // A level is accepted only once the second and third stage agree
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
         always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
               sync1[gi] <= SYNC_RESET[gi];
               sync2[gi] <= SYNC_RESET[gi];
               sync3[gi] <= SYNC_RESET[gi];
               pin_q[gi] <= SYNC_RESET[gi];
               pin_d[gi] <= SYNC_RESET[gi];
            end else begin
               sync1[gi] <= pin_raw[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
               if (sync2[gi] == sync3[gi]) begin
                  pin_q[gi] <= sync3[gi];
               end
               pin_d[gi] <= pin_q[gi];
            end
         end
      end
   endgenerate

   logic cs_q;
   logic din_q;
   logic sclk_rise;
   logic sclk_fall;

   assign cs_q      = pin_q[0];
   assign din_q     = pin_q[2];
   assign sclk_rise = pin_q[1] & ~pin_d[1];
   assign sclk_fall = ~pin_q[1] & pin_d[1];

   // ==========================================================
   // Sequencer
   localparam logic [1:0] ACQ_FALLS =
      VARIANT_DUAL ? DUAL_ACQ_FALLS : SINGLE_ACQ_FALLS;

   asp_state_type state;
   logic [1:0]    cfg_cnt;
   logic [1:0]    acq_cnt;
   logic [3:0]    bit_idx;
   logic          cfg_sgl;
   logic          cfg_odd;
   logic          cfg_msb_first_only;
   logic [11:0]   trial;
   logic [11:0]   next_trial;
   logic          want_lsb;

   // reversed copy follows unless only msb-first was asked
   // single-input variant always sends both orders
   assign want_lsb = VARIANT_DUAL ? ~cfg_msb_first_only : 1'b1;

   always_comb begin
      next_trial          = trial;
      next_trial[bit_idx] = comparator_above;
      if (bit_idx != RESULT_LSB) begin
         next_trial[bit_idx - 4'h1] = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state   <= ST_IDLE;
         cfg_cnt <= 2'h0;
         acq_cnt <= 2'h0;
         bit_idx <= RESULT_MSB;
      end else if (cs_q) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               // single-input variant goes straight to acquire
               state   <= VARIANT_DUAL ? ST_HUNT : ST_ACQUIRE;
               cfg_cnt <= 2'h0;
               acq_cnt <= 2'h0;
            end
            ST_HUNT: begin
               if (sclk_rise && din_q) begin
                  state <= ST_CONFIG;
               end
            end
            ST_CONFIG: begin
               if (sclk_rise) begin
                  cfg_cnt <= cfg_cnt + 2'h1;
                  if (cfg_cnt == CFG_MSB_FIRST_ONLY_IDX) begin
                     state <= ST_ACQUIRE;
                  end
               end
            end
            ST_ACQUIRE: begin
               // null bit on the counted falling edge
               if (sclk_fall) begin
                  acq_cnt <= acq_cnt + 2'h1;
                  if (acq_cnt + 2'h1 == ACQ_FALLS) begin
                     state   <= ST_CONVERT;
                     bit_idx <= RESULT_MSB;
                  end
               end
            end
            ST_CONVERT: begin
               // one result bit per shift clock, 12 in all
               if (sclk_fall) begin
                  if (bit_idx == RESULT_LSB) begin
                     state   <= want_lsb ? ST_LSB_OUT : ST_ZERO;
                     bit_idx <= RESULT_LSB + 4'h1;
                  end else begin
                     bit_idx <= bit_idx - 4'h1;
                  end
               end
            end
            ST_LSB_OUT: begin
               if (sclk_fall) begin
                  if (bit_idx == RESULT_MSB) begin
                     state <= ST_ZERO;
                  end else begin
                     bit_idx <= bit_idx + 4'h1;
                  end
               end
            end
            ST_ZERO: begin
               state <= ST_ZERO;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Configuration capture
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cfg_sgl  <= 1'b0;
         cfg_odd  <= 1'b0;
         cfg_msb_first_only <= 1'b0;
      end else if (VARIANT_DUAL && state == ST_CONFIG && sclk_rise) begin
         // single-ended select (cfg_sgl) follows the start bit directly
         // only this state ever loads the word
         case (cfg_cnt)
            CFG_SGL_IDX: cfg_sgl  <= din_q;
            CFG_ODD_IDX: cfg_odd  <= din_q;
            default:     cfg_msb_first_only <= din_q;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         mux_plus  <= LEG_GROUND;
         mux_minus <= LEG_GROUND;
      end else if (!VARIANT_DUAL) begin
         mux_plus  <= LEG_INPUT_A;
         mux_minus <= LEG_INPUT_B;
      end else begin
         mux_plus  <= cfg_odd ? LEG_INPUT_B : LEG_INPUT_A;
         if (cfg_sgl) begin
            mux_minus <= LEG_GROUND;
         end else begin
            mux_minus <= cfg_odd ? LEG_INPUT_A : LEG_INPUT_B;
         end
      end
   end

   // ==========================================================
   // Successive approximation
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         trial        <= TRIAL_START;
         result       <= RESULT_RESET;
         result_valid <= 1'b0;
      end else begin
         result_valid <= 1'b0;
         if (state != ST_CONVERT) begin
            if (state != ST_LSB_OUT && state != ST_ZERO) begin
               trial <= TRIAL_START;
            end
         end else if (sclk_rise) begin
            // straight binary code built msb down
            trial <= next_trial;
            if (bit_idx == RESULT_LSB) begin
               result       <= next_trial;
               result_valid <= 1'b1;
            end
         end
      end
   end

   assign dac_code = trial;

   // ==========================================================
   // Power and sampling controls
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         powered       <= 1'b0;
         bias_on       <= 1'b0;
         sample_enable <= 1'b0;
      end else begin
         powered <= ~cs_q;
         if (cs_q) begin
            bias_on       <= 1'b0;
            sample_enable <= 1'b0;
         end else begin
            if (state == ST_IDLE) begin
               bias_on       <= 1'b1;
               sample_enable <= ~VARIANT_DUAL;
            end
            // Tracking begins on the bit before msb_first_only
            if (state == ST_CONFIG && sclk_rise
                && cfg_cnt == CFG_ODD_IDX) begin
               sample_enable <= 1'b1;
            end
            if (state == ST_ACQUIRE && sclk_fall
                && acq_cnt + 2'h1 == ACQ_FALLS) begin
               sample_enable <= 1'b0;
            end
            // bias drops once the last bit is decided
            if (state == ST_CONVERT && sclk_rise
                && bit_idx == RESULT_LSB) begin
               bias_on <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Serial output driver
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         serial_out    <= 1'b0;
         serial_out_oe <= 1'b0;
      end else if (cs_q) begin
         serial_out    <= 1'b0;
         serial_out_oe <= 1'b0;
      end else if (sclk_fall) begin
         case (state)
            ST_ACQUIRE: begin
               if (acq_cnt + 2'h1 == ACQ_FALLS) begin
                  serial_out    <= 1'b0;
                  serial_out_oe <= 1'b1;
               end
            end
            ST_CONVERT: serial_out <= trial[bit_idx];
            ST_LSB_OUT: serial_out <= result[bit_idx];
            ST_ZERO:    serial_out <= 1'b0;
            default:    serial_out <= 1'b0;
         endcase
      end
   end

   // ==========================================================
   // Checks
   property p_idle_release;
      @(posedge clock) disable iff (!arst_n)
      cs_q |=> !serial_out_oe && state == ST_IDLE;
   endproperty
   a_idle_release: assert property (p_idle_release)
      else $error("output still driven with select high");

   property p_no_early_drive;
      @(posedge clock) disable iff (!arst_n)
      (state == ST_HUNT || state == ST_CONFIG) |-> !serial_out_oe;
   endproperty
   a_no_early_drive: assert property (p_no_early_drive)
      else $error("line driven before configuration ended");

   property p_null_bit;
      @(posedge clock) disable iff (!arst_n)
      $rose(serial_out_oe) |-> !serial_out && state == ST_CONVERT
         && $past(sclk_fall);
   endproperty
   a_null_bit: assert property (p_null_bit)
      else $error("driver did not open with a null bit");

   property p_shift_on_fall;
      @(posedge clock) disable iff (!arst_n)
      $changed(serial_out) |-> $past(sclk_fall) || $past(cs_q);
   endproperty
   a_shift_on_fall: assert property (p_shift_on_fall)
      else $error("output bit changed away from a falling edge");

   property p_zero_fill;
      @(posedge clock) disable iff (!arst_n)
      state == ST_ZERO && sclk_fall && !cs_q |=> !serial_out;
   endproperty
   a_zero_fill: assert property (p_zero_fill)
      else $error("nonzero bit after result transfer");

   property p_cfg_frozen;
      @(posedge clock) disable iff (!arst_n)
      state inside {ST_ACQUIRE, ST_CONVERT, ST_LSB_OUT, ST_ZERO}
         |=> $stable(cfg_msb_first_only) && $stable(cfg_sgl) && $stable(cfg_odd);
   endproperty
   a_cfg_frozen: assert property (p_cfg_frozen)
      else $error("configuration changed after capture");

   property p_bias_off;
      @(posedge clock) disable iff (!arst_n)
      result_valid |-> ##1 !bias_on [*2];
   endproperty
   a_bias_off: assert property (p_bias_off)
      else $error("bias still on after conversion");

   property p_powered;
      @(posedge clock) disable iff (!arst_n)
      cs_q ##1 cs_q |-> !powered;
   endproperty
   a_powered: assert property (p_powered)
      else $error("converter powered with select high");

   property p_mux_diff;
      @(posedge clock) disable iff (!arst_n)
      VARIANT_DUAL && !cfg_sgl && cfg_odd ##1 $stable(cfg_odd)
         && $stable(cfg_sgl) |-> mux_plus == LEG_INPUT_B
         && mux_minus == LEG_INPUT_A;
   endproperty
   a_mux_diff: assert property (p_mux_diff)
      else $error("differential reverse decode wrong");

   property p_msb_first_only_only;
      @(posedge clock) disable iff (!arst_n)
      VARIANT_DUAL && cfg_msb_first_only && state == ST_CONVERT
         && bit_idx == RESULT_LSB && sclk_fall && !cs_q
         |=> state == ST_ZERO;
   endproperty
   a_msb_first_only_only: assert property (p_msb_first_only_only)
      else $error("reversed copy sent though not requested");

endmodule

// File: shared/asp_pkg.sv
// Constants and encodings for the converter serial control port
//
// Contract
// - Bits change on falling shift clock, sampled on rising.
// - Single-input variant: no serial input; falling select starts transfer.
// - Single-input output enabled on second shift pulse after select falls.
// - Single-input variant sends one null bit, then the result bits.
// - Chip select high returns the port to idle for a new exchange.
// - Two-channel variant takes first sampled one as start bit, skips zeros.
// - After start, three config bits set input, order; conversion starts.
// - After configuration, serial input is ignored until chip select cycles.
// - Select bits decode to a-gnd, b-gnd, a-minus-b or b-minus-a.
// - Two-channel variant sends result msb first after the null bit.
// - msb_first_only one: result most significant first, then zeros.
// - msb_first_only zero: result then repeated lsb first.
// - Single-input variant always sends both orders; host may stop early.
// - After the result transfer, zeros follow while chip select stays low.
// - Result is 12-bit straight binary, zero to reference minus one step.
// - Chip select low powers the converter; high powers it down.
// - Bias and comparator power down after conversion; shifting continues.
// - Two-channel data in and out may share one half-duplex line.
// - Shared line: device drives low on fourth falling edge after start.
// - Sampling lasts about 1.5 clocks; conversion takes 12 shift clocks.
package asp_pkg;
   // ==========================================================
   // Result and configuration word
   localparam int          RESULT_BITS   = 12;
   localparam logic [3:0]  RESULT_MSB    = 4'hB;
   localparam logic [3:0]  RESULT_LSB    = 4'h0;
   localparam logic [11:0] TRIAL_START   = 12'h800;
   localparam logic [11:0] RESULT_RESET  = 12'h000;
   localparam logic [1:0]  CFG_SGL_IDX   = 2'h0;
   localparam logic [1:0]  CFG_ODD_IDX   = 2'h1;
   localparam logic [1:0]  CFG_MSB_FIRST_ONLY_IDX  = 2'h2;
   // ==========================================================
   // Falling edges from acquire entry to the null bit
   localparam logic [1:0]  SINGLE_ACQ_FALLS = 2'h2;
   localparam logic [1:0]  DUAL_ACQ_FALLS   = 2'h1;
   // ==========================================================
   // Pin synchroniser: bit 0 select, bit 1 clock, bit 2 data
   localparam int          PIN_COUNT     = 3;
   localparam logic [2:0]  SYNC_RESET    = 3'h1;
   // ==========================================================
   // Multiplexer leg codes
   localparam logic [1:0]  LEG_GROUND    = 2'h0;
   localparam logic [1:0]  LEG_INPUT_A   = 2'h1;
   localparam logic [1:0]  LEG_INPUT_B   = 2'h2;
   // ==========================================================
   // Port sequencer states
   typedef enum logic [6:0] {
      ST_IDLE    = 7'h01,
      ST_HUNT    = 7'h02,
      ST_CONFIG  = 7'h04,
      ST_ACQUIRE = 7'h08,
      ST_CONVERT = 7'h10,
      ST_LSB_OUT = 7'h20,
      ST_ZERO    = 7'h40
   } asp_state_type;
endpackage

// File: tb/asp_host_model.sv
// Host serial port model driving select, shift clock and data in
`timescale 1ns/10ps
module asp_host_model (
   // System clock used to pace the shift clock phases
   input  wire logic       clock,
   // Device outputs, bit 0 two-channel, bit 1 single-input
   input  wire logic [1:0] sout,
   input  wire logic [1:0] soe,
   // Host pins
   output logic            cs_n,
   output logic            sclk,
   output logic            sdin
);
   // ==========================================================
   // Captured device outputs, one entry per rising shift edge
   logic [1:0] cap    [0:39];
   logic [1:0] cap_oe [0:39];

   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdin = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clock);
         #1;
      end
   endtask

   // ==========================================================
   // One exchange; select stays low afterwards
   task automatic run(input int lead, input logic [2:0] cfg,
                      input int pulses);
      cs_n = 1'b0;
      tick(8);
      for (int p = 1; p <= pulses; p++) begin
         // zeros, start, then config in order
         if (p <= lead)
            sdin = 1'b0;
         else if (p == lead + 1)
            sdin = 1'b1;
         else if (p <= lead + 4)
            sdin = cfg[p - lead - 2];
         else
            // Toggling junk after config must be ignored
            sdin = p[0];
         // data set while clock low, captured on rise
         tick(8);
         sclk      = 1'b1;
         cap[p]    = sout;
         cap_oe[p] = soe;
         tick(8);
         sclk = 1'b0;
      end
      tick(8);
   endtask

   task automatic finish_cs;
      cs_n = 1'b1;
      sdin = 1'b0;
      tick(8);
   endtask
endmodule

// File: tb/asp_serial_port_bench.sv
// Self-checking bench for both variants of the serial port
`timescale 1ns/10ps
module asp_serial_port_bench;
   import asp_pkg::*;
   logic        clock;
   logic        arst_n;
   logic [11:0] va;
   logic [11:0] vb;
   int          errors;
   int          checks;
   wire logic   cs_n;
   wire logic   sclk;
   wire logic   sdin;
   wire logic [1:0]  so;
   wire logic [1:0]  oe;
   wire logic [11:0] dac_d;
   wire logic [11:0] dac_s;
   wire logic [1:0]  mux_p;
   wire logic [1:0]  mux_m;
   wire logic [11:0] res_d;
   wire logic [11:0] res_s;
   wire logic        bias_d;
   wire logic [1:0]  pwr;
   wire logic [1:0]  smp;
   wire logic [11:0] lp;
   wire logic [11:0] lm;
   wire logic [12:0] diff_d;
   wire logic [12:0] diff_s;
   wire logic        cmp_d;
   wire logic        cmp_s;

   // ==========================================================
   // Analog core: selected legs compared with the trial code
   assign lp = (mux_p == LEG_INPUT_A) ? va :
               (mux_p == LEG_INPUT_B) ? vb : 12'h000;
   assign lm = (mux_m == LEG_INPUT_A) ? va :
               (mux_m == LEG_INPUT_B) ? vb : 12'h000;
   assign diff_d = {1'b0, lp} - {1'b0, lm};
   assign diff_s = {1'b0, va} - {1'b0, vb};
   assign cmp_d  = !diff_d[12] && (diff_d[11:0] >= dac_d);
   assign cmp_s  = !diff_s[12] && (diff_s[11:0] >= dac_s);

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   asp_host_model u_asp_host_model (
      .clock (clock), .sout (so), .soe (oe),
      .cs_n (cs_n), .sclk (sclk), .sdin (sdin));

   asp_serial_port #(.VARIANT_DUAL(1'b1)) u_asp_serial_port_dual (
      .clock (clock), .arst_n (arst_n),
      .chip_select_shutdown_n (cs_n), .shift_clock (sclk),
      .serial_in (sdin), .serial_out (so[0]), .serial_out_oe (oe[0]),
      .comparator_above (cmp_d), .dac_code (dac_d),
      .mux_plus (mux_p), .mux_minus (mux_m), .sample_enable (smp[0]),
      .bias_on (bias_d), .powered (pwr[0]),
      .result (res_d), .result_valid ());

   asp_serial_port #(.VARIANT_DUAL(1'b0)) u_asp_serial_port_single (
      .clock (clock), .arst_n (arst_n),
      .chip_select_shutdown_n (cs_n), .shift_clock (sclk),
      .serial_in (sdin), .serial_out (so[1]), .serial_out_oe (oe[1]),
      .comparator_above (cmp_s), .dac_code (dac_s),
      .mux_plus (), .mux_minus (), .sample_enable (smp[1]),
      .bias_on (), .powered (pwr[1]),
      .result (res_s), .result_valid ());

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [11:0] clip(input logic [11:0] p,
                                        input logic [11:0] m);
      clip = (p >= m) ? p - m : 12'h000;
   endfunction

   // Bit q after the null bit: msb order, lsb copy from B1, zeros
   function automatic logic eb(input logic [11:0] c, input int q,
                               input logic lsb);
      if (q >= 1 && q <= 12)
         eb = c[12 - q];
      else if (q >= 13 && q <= 23)
         eb = lsb & c[q - 12];
      else
         eb = 1'b0;
   endfunction

   // ==========================================================
   // Full exchange on both variants at once
   task automatic t_exchange(input int lead, input logic [2:0] cfg,
                             input logic [11:0] a, input logic [11:0] b);
      logic [11:0] ed;
      logic [11:0] es;
      va = a;
      vb = b;
      case ({cfg[0], cfg[1]})
         2'b10:   ed = a;
         2'b11:   ed = b;
         2'b00:   ed = clip(a, b);
         default: ed = clip(b, a);
      endcase
      es = clip(a, b);
      u_asp_host_model.run(lead, cfg, lead + 31);
      check(res_d, ed);
      check(res_s, es);
      check({11'h000, u_asp_host_model.cap_oe[lead + 4][0]}, 12'h000);
      check({11'h000, u_asp_host_model.cap_oe[lead + 5][0]}, 12'h001);
      check({11'h000, u_asp_host_model.cap_oe[2][1]}, 12'h000);
      check({11'h000, u_asp_host_model.cap_oe[3][1]}, 12'h001);
      for (int p = lead + 5; p <= lead + 31; p++)
         check({11'h000, u_asp_host_model.cap[p][0]},
               {11'h000, eb(ed, p - lead - 5, !cfg[2])});
      for (int p = 3; p <= lead + 31; p++)
         check({11'h000, u_asp_host_model.cap[p][1]},
               {11'h000, eb(es, p - 3, 1'b1)});
      check({11'h000, bias_d}, 12'h000);
      check({10'h000, smp}, 12'h000);
      check({10'h000, pwr}, 12'h003);
      u_asp_host_model.finish_cs();
      check({10'h000, oe}, 12'h000);
      check({10'h000, pwr}, 12'h000);
   endtask

   // Select raised mid-conversion; port must go idle at once
   task automatic t_abort;
      u_asp_host_model.run(0, 3'b101, 9);
      check({10'h000, oe}, 12'h003);
      check({10'h000, smp}, 12'h000);
      u_asp_host_model.finish_cs();
      check({10'h000, oe}, 12'h000);
      check({10'h000, pwr}, 12'h000);
   endtask

   task automatic test_done;
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      errors = 0;
      checks = 0;
      va     = 12'h000;
      vb     = 12'h000;
      arst_n = 1'b0;
      repeat (8) @(posedge clock);
      #1;
      arst_n = 1'b1;
      u_asp_host_model.tick(8);
      t_exchange(0, 3'b101, 12'hA5C, 12'h123);
      t_abort();
      t_exchange(2, 3'b011, 12'h000, 12'hFFF);
      t_exchange(1, 3'b000, 12'h800, 12'h3FF);
      t_exchange(0, 3'b110, 12'h100, 12'hF00);
      t_exchange(3, 3'b110, 12'hF00, 12'h100);
      test_done();
   end

   // Watchdog bound on the whole run
   initial begin
      #200000;
      errors++;
      test_done();
   end
endmodule
